// *** rtl/asem_enc_chan.sv ***
// Purpose: one quadrature encoder channel, signed pulse count per window
// Assumes: phase pins are asynchronous to clk_i
// Notes: count saturates instead of wrapping
`timescale 1ns/1ps
module asem_enc_chan
	import asem_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Window strobe and phases
	input wire logic sample_i,
	input wire logic a_i,
	input wire logic b_i,
	// Result
	output logic signed [15:0] count_o,
	output logic fwd_o
);
	logic [1:0] a_q;
	logic [1:0] b_q;
	logic a_d;
	logic rise;
	logic signed [15:0] acc;
	logic signed [15:0] step;
	logic sat;

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers, not reset so a high A pin gives no false edge
	always_ff @(posedge clk_i) begin
		a_q <= {a_q[0], a_i};
		b_q <= {b_q[0], b_i};
		a_d <= a_q[1];
	end

	assign rise = a_q[1] & ~a_d;
	// Phase B level at the A rising edge gives the direction
	assign step = b_q[1] ? 16'sh0001 : -16'sh0001; // R6 R7
	assign sat = (acc == 16'sh7FFF) || (acc == -16'sh7FFF);

	// Accumulate edges, hand over at each window end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= 16'sh0000;
			count_o <= 16'sh0000;
		end else if (sample_i) begin
			count_o <= acc; // R23
			acc <= rise ? step : 16'sh0000;
		end else if (rise && !sat) begin
			acc <= acc + step;
		end
	end

	// Last seen direction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwd_o <= 1'b1;
		end else if (rise) begin
			fwd_o <= b_q[1]; // R6 R7
		end
	end
endmodule

// *** rtl/asem_pkg.sv ***
// Purpose: shared constants for the area select and encoder monitor
// Assumes: 250 MHz system clock, one aligned 32-bit word per register
// Notes: speeds are held as pulse counts per sample window
package asem_pkg;
	// Clock and time base
	localparam int CLK_MHZ = 250;
	localparam int MS_US = 1000;
	localparam int MS_CYC = MS_US * CLK_MHZ;
	localparam int TEST_PULSE_US = 300;
	localparam int TEST_CYC = TEST_PULSE_US * CLK_MHZ;
	localparam int TEST_PERIOD_MS = 100;
	localparam int SAMPLE_MS = 10;
	localparam int SPD_SCALE = MS_US / SAMPLE_MS;
	// Encoder limits and tolerance table
	localparam int ENC_FMAX_KHZ = 100;
	localparam int ENC_MAX_CNT = ENC_FMAX_KHZ * SAMPLE_MS;
	localparam int TOL_MAX_PCT = 80;
	localparam int TOL_LONG_MS = 60000;
	localparam int TOL_SHORT_MS = 20000;
	localparam int TOL_OPP_MS = 300;
	localparam int SPD_LOW_CMS = 9;
	localparam int SPD_HIGH_CMS = 30;
	localparam int AREAS = 32;
	// Register byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_PPCM = 8'h04;
	localparam logic [7:0] ADR_SETTLE = 8'h08;
	localparam logic [7:0] ADR_AREA_EN = 8'h0C;
	localparam logic [7:0] ADR_PAT = 8'h10;
	localparam logic [7:0] ADR_MON = 8'h14;
	localparam logic [7:0] ADR_STATUS = 8'h18;
	localparam logic [7:0] ADR_SPEED = 8'h1C;
	localparam logic [7:0] ADR_RNG = 8'h80;
	// Control and speed range entry field positions
	localparam int CTRL_PAIRS = 0;
	localparam int CTRL_ENC = 2;
	localparam int CTRL_DUAL = 3;
	localparam int CTRL_TOL = 4;
	localparam int RNG_AREA = 16;
	localparam int RNG_VALID = 31;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_00A3;
	localparam logic [15:0] PPCM_RST = 16'h0040;
	localparam logic [15:0] SETTLE_RST = 16'h001E;
	localparam logic [31:0] AREA_EN_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] PAT_RST = 32'h0000_0002;
	localparam logic [31:0] MON_RST = 32'h7FFF_8000;
	// Pattern use and self-test states
	typedef enum logic [1:0] {
		PAT_OFF = 2'b00,
		PAT_STATIC = 2'b01,
		PAT_ENC = 2'b10
	} asem_pat_t;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_PULSE = 2'b01,
		ST_LOCK = 2'b10
	} asem_st_t;
endpackage

// *** rtl/asem_sel_dec.sv ***
// Purpose: complementary select-pair decode with settling delay
// Assumes: select pins are asynchronous to clk_i
// Notes: area index is area number minus one
`timescale 1ns/1ps
module asem_sel_dec
	import asem_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Configuration
	input wire logic ms_tick_i,
	input wire logic [1:0] pairs_m1_i,
	input wire logic [15:0] settle_ms_i,
	// Select pins
	input wire logic [3:0] norm_i,
	input wire logic [3:0] inv_i,
	// Decoded result
	output logic [3:0] area_idx_o,
	output logic err_o,
	output logic valid_o
);
	logic [7:0] s1;
	logic [7:0] s2;
	logic [7:0] last;
	logic [3:0] mask;
	logic [15:0] cnt;
	logic change;

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for all eight lines
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= 8'h00;
			s2 <= 8'h00;
			last <= 8'h00;
		end else begin
			s1 <= {inv_i, norm_i};
			s2 <= s1;
			last <= s2;
		end
	end

	// Pairs above the configured count are ignored
	for (genvar i = 0; i < 4; i++) begin : g_mask
		assign mask[i] = (2'(i) <= pairs_m1_i);
	end

	assign change = (s2 != last);

	// Any movement restarts the settle time
	always_ff @(posedge clk_i) begin
		if (rst_i || change) begin
			cnt <= 16'h0000;
		end else if (ms_tick_i && cnt < settle_ms_i) begin
			cnt <= cnt + 16'h0001; // R20
		end
	end

	// Commit only a combination that stood for the whole delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			area_idx_o <= 4'h0;
			err_o <= 1'b0;
			valid_o <= 1'b0;
		end else if (!change && cnt >= settle_ms_i) begin
			area_idx_o <= ~s2[3:0] & mask; // R1 R2 R3 R4
			err_o <= |(mask & ~(s2[3:0] ^ s2[7:4])); // R19
			valid_o <= 1'b1;
		end
	end
endmodule

// *** rtl/asem_top.sv ***
// Purpose: area selection, encoder speed watch and safety output control
// Assumes: intrusion flags come from logic on clk_i; pins are asynchronous
// Notes: registers reached over classic Wishbone, one word each
//
// Summary of operation
// R1: four pairs give sixteen binary weighted areas
// R2: three pairs give eight areas, same weighting
// R3: two pairs give four areas
// R4: one pair selects area one or two
// R5: two quadrature encoder channel pairs, one each
// R6: B high at A rise means forward
// R7: B low at A rise means backward
// R8: watch both encoder speeds and directions constantly; the mismatch watch runs only above the low speed
// R9: speed mismatch tolerance settable zero to eighty percent
// R10: larger encoder speed is the vehicle speed
// R11: persistent mismatch turns outputs off, speed dependent
// R12: encoder mode: four patterns from two selects
// R13: encoder pattern picks area from speed ranges
// R14: measurable speed bounded by pulse rate limit
// R15: static pattern: fixed area, optional speed limits
// R16: intrusion in zone turns outputs off
// R17: periodic off test, error holds outputs off
// R18: paired safety outputs always identical
// R19: non complementary select pair is an error
// R20: settling delay before select change acts
// R21: test pulse lasts about 300 microseconds
// R22: dual mode: pair one zone one, pair two zone two
// R23: signed speed from counted edges per window
// R24: unconfigured area is a fault, outputs off
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module asem_top
	import asem_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC,
	parameter int TEST_CYCLES = TEST_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Select pairs and encoders
	input wire logic [3:0] sel_norm_i,
	input wire logic [3:0] sel_inv_i,
	input wire logic [1:0] enc_a_i,
	input wire logic [1:0] enc_b_i,
	// Detection and output read-back
	input wire logic zone1_intrude_i,
	input wire logic zone2_intrude_i,
	input wire logic [3:0] safety_fb_i,
	// Safety outputs and status
	output logic safety_out_1_o,
	output logic safety_out_2_o,
	output logic safety_out_3_o,
	output logic safety_out_4_o,
	output logic [4:0] area_o,
	output logic lockout_o
);
	if (MS_CYCLES < 2 || TEST_CYCLES < 4) begin : g_chk
		$error("asem_top: time base counts too small");
	end

	logic [31:0] ctrl;
	logic [15:0] ppcm;
	logic [15:0] settle_ms;
	logic [31:0] area_en;
	logic [31:0] pat_cfg;
	logic [31:0] mon_lim;
	logic [31:0] rng [AREAS];
	logic req;
	logic [31:0] wmask;
	logic [31:0] next_ctrl;
	logic [31:0] next_dat;
	logic [31:0] ms_cnt;
	logic ms_tick;
	logic [3:0] win_cnt;
	logic sample;
	logic signed [15:0] cnt1;
	logic signed [15:0] cnt2;
	logic [1:0] fwd;
	logic [3:0] sel_idx;
	logic sel_err;
	logic sel_valid;
	logic [6:0] tol;
	logic enc_mode;
	logic dual;

	assign tol = ctrl[CTRL_TOL +: 7];
	assign enc_mode = ctrl[CTRL_ENC];
	assign dual = ctrl[CTRL_DUAL] & ~enc_mode;

	////////////////////////////////////////////////////////////////////////
	// Register bus: one wait state, ack drops the cycle after it rose
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	for (genvar i = 0; i < 4; i++) begin : g_be
		assign wmask[8*i +: 8] = {8{wb_sel_i[i]}};
	end

	// Tolerance field clamps at its documented top
	always_comb begin
		next_ctrl = (ctrl & ~wmask) | (wb_dat_i & wmask);
		if (next_ctrl[CTRL_TOL +: 7] > 7'(TOL_MAX_PCT)) begin
			next_ctrl[CTRL_TOL +: 7] = 7'(TOL_MAX_PCT); // R9
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// Writable configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RST;
			ppcm <= PPCM_RST;
			settle_ms <= SETTLE_RST;
			area_en <= AREA_EN_RST;
			pat_cfg <= PAT_RST;
			mon_lim <= MON_RST;
		end else if (req && wb_we_i) begin
			unique case (wb_adr_i)
				ADR_CTRL: ctrl <= next_ctrl;
				ADR_PPCM: ppcm <= (ppcm & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				ADR_SETTLE: settle_ms <= (settle_ms & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				ADR_AREA_EN: area_en <= (area_en & ~wmask) | (wb_dat_i & wmask);
				ADR_PAT: pat_cfg <= (pat_cfg & ~wmask) | (wb_dat_i & wmask);
				ADR_MON: mon_lim <= (mon_lim & ~wmask) | (wb_dat_i & wmask);
				default: ;
			endcase
		end
	end

	// Speed range table, cleared to invalid at reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < AREAS; i++) begin
				rng[i] <= 32'h0000_0000;
			end
		end else if (req && wb_we_i && wb_adr_i[7] && wb_adr_i[1:0] == 2'h0) begin
			rng[wb_adr_i[6:2]] <= (rng[wb_adr_i[6:2]] & ~wmask) | (wb_dat_i & wmask); // R13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick and sample window
	always_ff @(posedge clk_i) begin
		if (rst_i || ms_tick) begin
			ms_cnt <= 32'h0000_0000;
		end else begin
			ms_cnt <= ms_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_cnt <= 4'h0;
		end else if (ms_tick) begin
			win_cnt <= (win_cnt == 4'(SAMPLE_MS - 1)) ? 4'h0 : win_cnt + 4'h1;
		end
	end

	assign ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
	assign sample = ms_tick && win_cnt == 4'(SAMPLE_MS - 1);

	// Two independent encoder channels
	for (genvar e = 0; e < 2; e++) begin : g_enc
		logic signed [15:0] c;
		asem_enc_chan u_enc (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.sample_i(sample),
			.a_i(enc_a_i[e]), // R5
			.b_i(enc_b_i[e]),
			.count_o(c),
			.fwd_o(fwd[e])
		);
	end
	assign cnt1 = g_enc[0].c;
	assign cnt2 = g_enc[1].c;

	// Select pair decoder
	asem_sel_dec u_sel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ms_tick_i(ms_tick),
		.pairs_m1_i(enc_mode ? 2'h1 : ctrl[CTRL_PAIRS +: 2]), // R12
		.settle_ms_i(settle_ms),
		.norm_i(sel_norm_i),
		.inv_i(sel_inv_i),
		.area_idx_o(sel_idx),
		.err_o(sel_err),
		.valid_o(sel_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// Speed arithmetic; thresholds are scaled by pulses per cm, not divided
	logic [16:0] abs1;
	logic [16:0] abs2;
	logic [16:0] vmax;
	logic [16:0] vdiff;
	logic signed [15:0] vsp;
	logic [39:0] vabs_s;
	logic signed [39:0] vsp_s;
	logic signed [39:0] ppcm_s;
	logic opp;
	logic above_lo;
	logic high;
	logic mismatch;
	logic [16:0] limit;
	logic [16:0] mis_ms;

	assign abs1 = cnt1[15] ? 17'(-$signed({cnt1[15], cnt1})) : {1'b0, cnt1};
	assign abs2 = cnt2[15] ? 17'(-$signed({cnt2[15], cnt2})) : {1'b0, cnt2};
	assign vmax = (abs1 >= abs2) ? abs1 : abs2; // R10
	assign vsp = (abs1 >= abs2) ? cnt1 : cnt2; // R10
	assign vdiff = (abs1 >= abs2) ? abs1 - abs2 : abs2 - abs1;
	assign vabs_s = 40'(vmax) * 40'(SPD_SCALE);
	assign vsp_s = 40'(vsp) * 40'sd100;
	assign ppcm_s = $signed({24'h000000, ppcm});
	assign opp = (cnt1 > 0 && cnt2 < 0) || (cnt1 < 0 && cnt2 > 0);
	assign above_lo = vabs_s > 40'(ppcm) * 40'(SPD_LOW_CMS);
	assign high = vabs_s >= 40'(ppcm) * 40'(SPD_HIGH_CMS);
	// No mismatch watch at or below the low speed
	assign mismatch = above_lo && (opp || 40'(vdiff) * 40'd100 > 40'(tol) * 40'(vmax)); // R8 R9 R11
	assign limit = opp ? 17'(TOL_OPP_MS) : (high ? 17'(TOL_SHORT_MS) : 17'(TOL_LONG_MS)); // R11

	// Mismatch duration in milliseconds
	always_ff @(posedge clk_i) begin
		if (rst_i || !mismatch) begin
			mis_ms <= 17'h00000;
		end else if (ms_tick && mis_ms < limit) begin
			mis_ms <= mis_ms + 17'h00001; // R11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Speed range lookup: lowest valid entry whose upper bound holds vsp
	logic [AREAS-1:0] hit;
	logic [4:0] rng_area;
	logic rng_hit;

	for (genvar i = 0; i < AREAS; i++) begin : g_rng
		assign hit[i] = rng[i][RNG_VALID] && vsp_s <= 40'($signed(rng[i][15:0])) * ppcm_s;
	end

	always_comb begin
		rng_area = 5'h00;
		rng_hit = 1'b0;
		for (int i = AREAS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				rng_area = rng[i][RNG_AREA +: 5]; // R13
				rng_hit = 1'b1;
			end
		end
	end

	// Area choice and its faults
	logic [7:0] pc;
	logic has_enc;
	logic [4:0] next_area;
	logic next_area_flt;
	logic next_spd_flt;
	logic area_flt;
	logic spd_flt;
	logic mis_flt;
	logic ovr_flt;

	assign pc = pat_cfg[8 * sel_idx[1:0] +: 8];
	assign has_enc = pat_cfg[1] | pat_cfg[9] | pat_cfg[17] | pat_cfg[25];

	always_comb begin
		next_area = {1'b0, sel_idx}; // R1 R2 R3 R4
		next_area_flt = 1'b0;
		next_spd_flt = 1'b0;
		if (enc_mode) begin
			next_area = 5'h00;
			next_area_flt = !has_enc; // R12
			unique case (pc[1:0])
				PAT_STATIC: begin
					next_area = pc[6:2]; // R15
					next_spd_flt = pc[7] && (vsp_s < 40'($signed(mon_lim[15:0])) * ppcm_s ||
						vsp_s > 40'($signed(mon_lim[31:16])) * ppcm_s); // R15
				end
				PAT_ENC: begin
					next_area = rng_area;
					next_area_flt = next_area_flt | !rng_hit; // R13
				end
				PAT_OFF: next_area_flt = 1'b1;
				default: next_area_flt = 1'b1;
			endcase
		end
		if (!area_en[next_area]) begin
			next_area_flt = 1'b1; // R24
		end
	end

	// Registered area and fault levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			area_o <= 5'h00;
			area_flt <= 1'b1;
			spd_flt <= 1'b0;
			mis_flt <= 1'b0;
			ovr_flt <= 1'b0;
		end else begin
			area_o <= next_area;
			area_flt <= next_area_flt | !sel_valid;
			spd_flt <= next_spd_flt;
			mis_flt <= mismatch && mis_ms >= limit; // R11
			ovr_flt <= abs1 > 17'(ENC_MAX_CNT) || abs2 > 17'(ENC_MAX_CNT); // R14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output self-test: periodic off pulse, read-back checked at its end
	asem_st_t st;
	logic [6:0] per_ms;
	logic [31:0] pul_cnt;
	logic [3:0] fb1;
	logic [3:0] fb2;
	logic [3:0] tested;
	logic pulse_end;

	assign tested = dual ? 4'hF : 4'h3;
	assign pulse_end = pul_cnt == 32'(TEST_CYCLES - 1);

	// Read-back pins are asynchronous
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fb1 <= 4'h0;
			fb2 <= 4'h0;
		end else begin
			fb1 <= safety_fb_i;
			fb2 <= fb1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= ST_RUN;
			per_ms <= 7'h00;
			pul_cnt <= 32'h0000_0000;
		end else begin
			unique case (st)
				ST_RUN: begin
					pul_cnt <= 32'h0000_0000;
					if (ms_tick) begin
						per_ms <= per_ms + 7'h01;
					end
					if (ms_tick && per_ms == 7'(TEST_PERIOD_MS - 1)) begin
						per_ms <= 7'h00;
						st <= ST_PULSE; // R17
					end
				end
				ST_PULSE: begin
					pul_cnt <= pul_cnt + 32'h0000_0001; // R21
					if (pulse_end) begin
						// A tested output still high while off means a stuck driver
						st <= |(fb2 & tested) ? ST_LOCK : ST_RUN; // R17
					end
				end
				ST_LOCK: st <= ST_LOCK; // R17
				default: st <= ST_LOCK;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Safety outputs: any fault or test pulse, or an intrusion in their own zone, forces off
	logic fault;
	logic z1_on;
	logic z2_on;

	assign fault = (st == ST_LOCK) | sel_err | area_flt | spd_flt | mis_flt | ovr_flt; // R8 R24
	assign z1_on = !fault && !zone1_intrude_i && st != ST_PULSE; // R16 R17
	assign z2_on = dual && !fault && !zone2_intrude_i && st != ST_PULSE; // R16 R22

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			safety_out_1_o <= 1'b0;
			safety_out_2_o <= 1'b0;
			safety_out_3_o <= 1'b0;
			safety_out_4_o <= 1'b0;
			lockout_o <= 1'b0;
		end else begin
			safety_out_1_o <= z1_on; // R18
			safety_out_2_o <= z1_on; // R18
			safety_out_3_o <= z2_on; // R18 R22
			safety_out_4_o <= z2_on; // R18 R22
			lockout_o <= st == ST_LOCK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data; unmapped words read as zero
	always_comb begin
		next_dat = 32'h0000_0000;
		if (wb_adr_i[7]) begin
			next_dat = rng[wb_adr_i[6:2]];
		end else begin
			unique case (wb_adr_i)
				ADR_CTRL: next_dat = ctrl;
				ADR_PPCM: next_dat = {16'h0000, ppcm};
				ADR_SETTLE: next_dat = {16'h0000, settle_ms};
				ADR_AREA_EN: next_dat = area_en;
				ADR_PAT: next_dat = pat_cfg;
				ADR_MON: next_dat = mon_lim;
				ADR_STATUS: next_dat = {14'h0000, fwd, safety_out_4_o, safety_out_3_o, safety_out_2_o,
					safety_out_1_o, lockout_o, ovr_flt, mis_flt, spd_flt, area_flt, sel_err,
					sel_valid, area_o};
				ADR_SPEED: next_dat = {cnt2, cnt1};
				default: next_dat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req) begin
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : next_dat;
		end
	end
endmodule

// *** tb/asem_enc_model.sv ***
// Purpose: two quadrature encoders and the output read-back
// Assumes: step period of each encoder is 3 cycles or more
// Notes: stuck_i holds read-back high, as a welded contact would
`timescale 1ns/1ps
module asem_enc_model (
	// Clock and control
	input wire logic clk_i,
	input wire logic [1:0] fwd_i,
	input wire logic [7:0] q1_i,
	input wire logic [7:0] q2_i,
	input wire logic stuck_i,
	input wire logic [3:0] out_i,
	// Phases and read-back
	output logic [1:0] a_o,
	output logic [1:0] b_o,
	output logic [3:0] fb_o
);
	logic [1:0][1:0] ph = '0;
	logic [1:0][7:0] c = '0;
	////////////////////////////////////////
	// Gray position steps; forward lets B lead A
	always @(posedge clk_i) begin
		for (int i = 0; i < 2; i++) begin
			c[i] <= (c[i] + 8'h01 >= (i ? q2_i : q1_i)) ? 8'h00 : c[i] + 8'h01;
			if (c[i] == 8'h00)
				ph[i] <= fwd_i[i] ? ph[i] + 2'h1 : ph[i] - 2'h1;
		end
	end
	// Position 0..3 maps to AB 00, 01, 11, 10
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			a_o[i] = ph[i][1];
			b_o[i] = ph[i][1] ^ ph[i][0];
		end
		fb_o = stuck_i ? 4'hF : out_i;
	end
endmodule

// *** tb/asem_top_asserts.sv ***
// Purpose: port checker for the area select and encoder monitor
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
module asem_top_asserts #(
	parameter int MS_CYCLES = 10,
	parameter int TEST_CYCLES = 8
) (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Pins watched
	input wire logic zone1_intrude_i,
	input wire logic [3:0] sel_norm_i,
	input wire logic [3:0] sel_inv_i,
	input wire logic safety_out_1_o,
	input wire logic safety_out_2_o,
	input wire logic safety_out_3_o,
	input wire logic safety_out_4_o,
	input wire logic [4:0] area_o,
	input wire logic lockout_o
);
	////////////////////////////////////////
	// One clock domain, so reset masks every check once here
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Outputs and pairing
	pair_one_a: assert property (safety_out_1_o == safety_out_2_o) else $error("out 1 and 2 differ");
	pair_two_a: assert property (safety_out_3_o == safety_out_4_o) else $error("out 3 and 4 differ");
	zone_off_a: assert property (zone1_intrude_i [*3] |=> !safety_out_1_o) else $error("intrusion kept on");
	// A bad first pair must turn out 1 off once a settle of up to 30 ms has run
	int bad_cnt;
	always @(posedge clk_i)
		bad_cnt <= (rst_i || sel_norm_i[0] != sel_inv_i[0]) ? 0 : bad_cnt + (bad_cnt < 32 * MS_CYCLES + 4);
	sel_err_a: assert property (bad_cnt == 32 * MS_CYCLES + 4 |-> !safety_out_1_o) else $error("bad pair on");
	lock_off_a: assert property (lockout_o |-> !safety_out_1_o && !safety_out_3_o) else $error("on in lockout");
	lock_hold_a: assert property (lockout_o |=> lockout_o) else $error("lockout cleared");
	reset_off_a: assert property ($fell(rst_i) |-> !safety_out_1_o && area_o == 5'h00 && !lockout_o)
		else $error("not off after reset");
	// Bus handshake
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_take_a: assert property (take |=> wb_ack_o) else $error("ack late");
	dat_hold_a: assert property (!$past(take) |-> $stable(wb_dat_o)) else $error("read data moved");
	// Main scenarios
	cover property (lockout_o);
	cover property (zone1_intrude_i ##3 !safety_out_1_o);
	cover property ($fell(safety_out_1_o) && !zone1_intrude_i);
endmodule

// *** tb/tb_asem_top.sv ***
// Purpose: self-checking bench for the area select and encoder monitor
// Assumes: 10 cycles stand for 1 ms, test pulse 8 cycles
// Notes: tests run in a fixed order, lockout last
`timescale 1ns/1ps
module tb_asem_top;
	import asem_pkg::*;
	localparam int TC = 8;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hF, sel_norm_i = 4'hF, sel_inv_i = 4'h0, safety_fb_i;
	logic [31:0] wb_dat_i = '0, wb_dat_o;
	logic zone1_intrude_i = 0, zone2_intrude_i = 0, stuck = 0, wb_ack_o, lockout_o;
	logic safety_out_1_o, safety_out_2_o, safety_out_3_o, safety_out_4_o;
	logic [1:0] enc_a_i, enc_b_i, fwd = 2'h3;
	logic [7:0] q1 = 8'h05, q2 = 8'h05;
	logic [4:0] area_o;
	int fail_count = 0, checks_done = 0, tmo = 0;
	asem_top #(.MS_CYCLES(10), .TEST_CYCLES(TC)) uut (.*);
	asem_enc_model em (.clk_i(clk_i), .fwd_i(fwd), .q1_i(q1), .q2_i(q2), .stuck_i(stuck),
		.out_i({safety_out_4_o, safety_out_3_o, safety_out_2_o, safety_out_1_o}),
		.a_o(enc_a_i), .b_o(enc_b_i), .fb_o(safety_fb_i));
	always #2 clk_i = ~clk_i;
	////////////////////////////////////////
	// Compare, bus and wait helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Request holds until ack is sampled high at an edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, q);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_on();
		while (safety_out_1_o !== 1'b1) @(posedge clk_i);
	endtask
	////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		logic [31:0] x;
		logic [7:0] ad [7] = '{ADR_CTRL, ADR_PPCM, ADR_SETTLE, ADR_AREA_EN, ADR_PAT, ADR_MON, 8'h40};
		logic [31:0] ev [7] = '{CTRL_RST, 32'(PPCM_RST), 32'(SETTLE_RST), AREA_EN_RST, PAT_RST, MON_RST, 32'h0};
		wr(8'h40, 32'hFFFF_FFFF);
		for (int i = 0; i < 7; i++) begin
			rd(ad[i], x);
			chk("reset value", ev[i], x);
		end
		wr(ADR_CTRL, 32'h0000_0643);
		rd(ADR_CTRL, x);
		chk("tolerance clamp", 32'h0000_0503, x);
		$display("t_regs done");
	endtask
	task automatic t_sel();
		wr(ADR_SETTLE, 32'h0000_0002);
		for (int p = 0; p < 4; p++) begin
			wr(ADR_CTRL, 32'hA0 | p);
			for (int i = 0; i < (2 << p); i++) begin
				sel_norm_i <= ~4'(i);
				sel_inv_i <= 4'(i);
				cyc(60);
				chk("area", 32'(i), 32'(area_o));
			end
		end
		sel_norm_i <= ~4'h5;
		sel_inv_i <= 4'h5;
		cyc(12);
		chk("area settling", 32'hF, 32'(area_o));
		cyc(48);
		chk("area settled", 32'h5, 32'(area_o));
		$display("t_sel done");
	endtask
	task automatic t_err();
		logic [31:0] x;
		sel_norm_i <= 4'hF;
		sel_inv_i <= 4'h1;
		cyc(330);
		chk("pair error out", 32'h0, 32'(safety_out_1_o));
		rd(ADR_STATUS, x);
		chk("pair error flag", 32'h1, 32'(x[6]));
		sel_inv_i <= 4'h0;
		cyc(60);
		wr(ADR_AREA_EN, 32'hFFFF_FFFE);
		cyc(5);
		chk("area fault out", 32'h0, 32'(safety_out_1_o));
		rd(ADR_STATUS, x);
		chk("area fault flag", 32'h1, 32'(x[7]));
		wr(ADR_AREA_EN, 32'hFFFF_FFFF);
		$display("t_err done");
	endtask
	task automatic t_zone();
		wait_on();
		zone1_intrude_i <= 1;
		cyc(4);
		chk("zone1 out1", 32'h0, 32'(safety_out_1_o));
		chk("zone1 out2", 32'h0, 32'(safety_out_2_o));
		zone1_intrude_i <= 0;
		wr(ADR_CTRL, 32'hAB);
		zone2_intrude_i <= 1;
		cyc(3);
		wait_on();
		chk("zone2 out3", 32'h0, 32'(safety_out_3_o));
		zone2_intrude_i <= 0;
		cyc(2);
		wait_on();
		chk("zone2 out4", 32'h1, 32'(safety_out_4_o));
		$display("t_zone done");
	endtask
	task automatic t_pulse();
		int m = 0;
		wr(ADR_CTRL, 32'hA3);
		wait_on();
		while (safety_out_1_o === 1'b1) @(posedge clk_i);
		while (safety_out_1_o !== 1'b1) begin
			@(posedge clk_i);
			m++;
		end
		chk("test pulse", 32'(TC), 32'(m));
		$display("t_pulse done");
	endtask
	task automatic t_enc();
		logic [31:0] x;
		wr(ADR_PPCM, 32'h1);
		wr(ADR_CTRL, 32'h507);
		wr(ADR_RNG, 32'h8003_012C);
		wr(ADR_RNG + 8'h04, 32'h8005_03E8);
		q2 <= 8'h19;
		cyc(300);
		rd(ADR_SPEED, x);
		chk("speed fwd", 32'h0001_0005, x);
		chk("range area", 32'h5, 32'(area_o));
		rd(ADR_STATUS, x);
		chk("dir fwd", 32'h3, 32'(x[17:16]));
		fwd <= 2'h0;
		cyc(300);
		rd(ADR_SPEED, x);
		chk("speed back", 32'hFFFF_FFFB, x);
		rd(ADR_STATUS, x);
		chk("dir back", 32'h0, 32'(x[17:16]));
		fwd <= 2'h3;
		wr(ADR_PAT, 32'h289);
		wr(ADR_MON, 32'h0064_FFEC);
		cyc(300);
		chk("static area", 32'h2, 32'(area_o));
		rd(ADR_STATUS, x);
		chk("limit fault", 32'h1, 32'(x[8]));
		chk("limit out", 32'h0, 32'(safety_out_1_o));
		$display("t_enc done");
	endtask
	// Opposite turning must trip after 300 ms and not long before
	task automatic t_opp();
		logic [31:0] x;
		wr(ADR_PAT, 32'h201);
		q2 <= 8'h05;
		fwd <= 2'h1;
		cyc(2700);
		rd(ADR_STATUS, x);
		chk("opposite early", 32'h0, 32'(x[9]));
		cyc(800);
		rd(ADR_STATUS, x);
		chk("opposite fault", 32'h1, 32'(x[9]));
		chk("opposite out", 32'h0, 32'(safety_out_1_o));
		fwd <= 2'h3;
		$display("t_opp done");
	endtask
	task automatic t_lock();
		stuck <= 1;
		while (lockout_o !== 1'b1) @(posedge clk_i);
		stuck <= 0;
		cyc(50);
		chk("lockout held", 32'h1, 32'(lockout_o));
		chk("lockout out", 32'h0, 32'(safety_out_1_o));
		rst_i <= 1;
		cyc(3);
		rst_i <= 0;
		cyc(2);
		chk("lockout reset", 32'h0, 32'(lockout_o));
		$display("t_lock done");
	endtask
	////////////////////////////////////////
	// Verdict and run control
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// A hang ends here rather than running forever
	always @(posedge clk_i) begin
		tmo <= tmo + 1;
		if (tmo == 30000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		cyc(12);
		rst_i <= 0;
		t_regs();
		t_sel();
		t_err();
		t_zone();
		t_pulse();
		t_enc();
		t_opp();
		t_lock();
		results();
	end
endmodule
bind asem_top asem_top_asserts #(.MS_CYCLES(MS_CYCLES), .TEST_CYCLES(TEST_CYCLES)) chk_u (.*);
